// file: core/cwwp_pkg.sv
package cwwp_pkg;

	localparam int ADDR_W = 14;
	localparam int WORD_W = 14;
	localparam int PA_W   = 12;
	localparam int BND_W  = 13;

	localparam logic [ADDR_W-1:0] CFG1_ADDR = 14'h2007;
	localparam logic [ADDR_W-1:0] CFG2_ADDR = 14'h2008;

	// Implemented (stored) bits; all others read as one
	localparam logic [WORD_W-1:0] CFG1_IMPL   = 14'h137b;
	localparam logic [WORD_W-1:0] CFG2_IMPL   = 14'h0013;
	localparam logic [WORD_W-1:0] WORD_ERASED = 14'h3fff;
	localparam logic [WORD_W-1:0] UNMAPPED_RD = 14'h0000;

	// Word 1 field positions
	localparam int PLL_BIT   = 12;
	localparam int BOR_LSB   = 8;
	localparam int CP_BIT    = 6;
	localparam int RPIN_BIT  = 5;
	localparam int PWRT_BIT  = 4;
	localparam int WDT_BIT   = 3;
	localparam int OSC_LSB   = 0;
	// Word 2 field positions
	localparam int WRT_LSB   = 0;
	localparam int RSVD_BIT  = 4;

	// Program memory bounds (first writable address / end of memory)
	localparam logic [BND_W-1:0] BND_NONE   = 13'h0000;
	localparam logic [BND_W-1:0] BND_SMALL  = 13'h0200;
	localparam logic [BND_W-1:0] BND_MID_2K = 13'h0400;
	localparam logic [BND_W-1:0] BND_MID_4K = 13'h0800;
	localparam logic [BND_W-1:0] END_2K     = 13'h0800;
	localparam logic [BND_W-1:0] END_4K     = 13'h1000;

	typedef enum logic [1:0] {
		CWWP_WP_ALL   = 2'b00,
		CWWP_WP_MID   = 2'b01,
		CWWP_WP_SMALL = 2'b10,
		CWWP_WP_OFF   = 2'b11
	} cwwp_wrt_t;

	typedef struct packed {
		logic       pll_enable_opt;
		logic [1:0] brownout_mode_opt;
		logic       code_protect_opt;
		logic       reset_pin_function_opt;
		logic       powerup_timer_opt;
		logic       watchdog_enable_opt;
		logic [1:0] osc_select_opt;
	} cwwp_opts_t;

endpackage

// file: core/cwwp_top.sv
`timescale 1ns/1ps
module cwwp_top #(
	parameter bit IS_4K = 1'b0
) (
	input  wire logic                             mclk_i,
	input  wire logic                             rst_i,
	input  wire logic                             nv_load_i,
	input  wire logic [cwwp_pkg::WORD_W-1:0]      nv_word1_i,
	input  wire logic [cwwp_pkg::WORD_W-1:0]      nv_word2_i,
	input  wire logic                             prog_mode_i,
	input  wire logic [cwwp_pkg::ADDR_W-1:0]      prog_addr_i,
	input  wire logic                             prog_wr_i,
	input  wire logic [cwwp_pkg::WORD_W-1:0]      prog_wdata_i,
	input  wire logic                             prog_rd_i,
	output logic      [cwwp_pkg::WORD_W-1:0]      prog_rdata_o,
	output logic                                  prog_rvalid_o,
	input  wire logic                             sw_req_i,
	input  wire logic [cwwp_pkg::PA_W-1:0]        sw_addr_i,
	output logic                                  sw_grant_o,
	output logic                                  sw_block_o,
	output cwwp_pkg::cwwp_opts_t                  opts_o,
	output cwwp_pkg::cwwp_wrt_t                   self_write_protect_sel_o
);
	////////////////////////////////////////////////////////////////////////////
	// Programming mode entry pin synchroniser
	logic prog_mode_meta_reg;
	logic prog_mode_reg;

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			prog_mode_meta_reg <= 1'b0;
			prog_mode_reg      <= 1'b0;
		end else begin
			prog_mode_meta_reg <= prog_mode_i;
			prog_mode_reg      <= prog_mode_meta_reg;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Configuration word storage
	logic                        hit1;
	logic                        hit2;
	logic                        wr1;
	logic                        wr2;
	logic [cwwp_pkg::WORD_W-1:0] word1;
	logic [cwwp_pkg::WORD_W-1:0] word2;

	assign hit1 = (prog_addr_i == cwwp_pkg::CFG1_ADDR);
	assign hit2 = (prog_addr_i == cwwp_pkg::CFG2_ADDR);
	// Core execution has no path here; only the programming port and the nonvolatile load write
	assign wr1  = prog_mode_reg && prog_wr_i && hit1;
	assign wr2  = prog_mode_reg && prog_wr_i && hit2;

	cwwp_word_reg #(
		.IMPL_MASK (cwwp_pkg::CFG1_IMPL)
	) u_word1 (
		.mclk_i      (mclk_i),
		.rst_i       (rst_i),
		.load_i      (nv_load_i),
		.load_data_i (nv_word1_i),
		.wr_i        (wr1),
		.wr_data_i   (prog_wdata_i),
		.word_o      (word1)
	);

	// Reserved bit 4 is stored as written so a verify shows what was programmed
	cwwp_word_reg #(
		.IMPL_MASK (cwwp_pkg::CFG2_IMPL)
	) u_word2 (
		.mclk_i      (mclk_i),
		.rst_i       (rst_i),
		.load_i      (nv_load_i),
		.load_data_i (nv_word2_i),
		.wr_i        (wr2),
		.wr_data_i   (prog_wdata_i),
		.word_o      (word2)
	);

	////////////////////////////////////////////////////////////////////////////
	// Programming read port
	logic [cwwp_pkg::WORD_W-1:0] rdata_next;

	always_comb begin
		if (hit1) begin
			rdata_next = word1;
		end else if (hit2) begin
			rdata_next = word2;
		end else begin
			rdata_next = cwwp_pkg::UNMAPPED_RD;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			prog_rdata_o <= cwwp_pkg::UNMAPPED_RD;
		end else if (prog_mode_reg && prog_rd_i) begin
			prog_rdata_o <= rdata_next;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			prog_rvalid_o <= 1'b0;
		end else begin
			prog_rvalid_o <= prog_mode_reg && prog_rd_i;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Option decode of word 1
	always_comb begin
		opts_o.pll_enable_opt         = word1[cwwp_pkg::PLL_BIT];
		opts_o.brownout_mode_opt      = word1[cwwp_pkg::BOR_LSB +: 2];
		opts_o.code_protect_opt       = word1[cwwp_pkg::CP_BIT];
		opts_o.reset_pin_function_opt = word1[cwwp_pkg::RPIN_BIT];
		opts_o.powerup_timer_opt      = word1[cwwp_pkg::PWRT_BIT];
		opts_o.watchdog_enable_opt    = word1[cwwp_pkg::WDT_BIT];
		opts_o.osc_select_opt         = word1[cwwp_pkg::OSC_LSB +: 2];
	end

	////////////////////////////////////////////////////////////////////////////
	// Self-write protection decode
	localparam logic [cwwp_pkg::BND_W-1:0] MEM_END = IS_4K ? cwwp_pkg::END_4K : cwwp_pkg::END_2K;
	localparam logic [cwwp_pkg::BND_W-1:0] BND_MID =
		IS_4K ? cwwp_pkg::BND_MID_4K : cwwp_pkg::BND_MID_2K;

	logic [cwwp_pkg::BND_W-1:0] first_free;
	logic [cwwp_pkg::BND_W-1:0] sw_addr_ext;
	logic                       protected_hit;

	assign self_write_protect_sel_o = cwwp_pkg::cwwp_wrt_t'(word2[cwwp_pkg::WRT_LSB +: 2]);

	always_comb begin
		unique case (self_write_protect_sel_o)
			cwwp_pkg::CWWP_WP_OFF:   first_free = cwwp_pkg::BND_NONE;
			cwwp_pkg::CWWP_WP_SMALL: first_free = cwwp_pkg::BND_SMALL;
			cwwp_pkg::CWWP_WP_MID:   first_free = BND_MID;
			cwwp_pkg::CWWP_WP_ALL:   first_free = MEM_END;
		endcase
	end

	assign sw_addr_ext = {1'b0, sw_addr_i};
	// Addresses past the fitted memory are refused too, so a 2K part never aliases
	assign protected_hit = (sw_addr_ext < first_free) || (sw_addr_ext >= MEM_END);
	assign sw_grant_o    = sw_req_i && !protected_hit;
	assign sw_block_o    = sw_req_i && protected_hit;

	////////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (rst_i);

	a_word1_write:  assert property (prog_mode_reg && prog_wr_i && hit1 |=>
		word1 == ($past(prog_wdata_i) | ~cwwp_pkg::CFG1_IMPL))
		else $error("word 1 not updated by programming write");
	a_word2_read:   assert property (prog_mode_reg && prog_rd_i && hit2 |=>
		prog_rvalid_o && prog_rdata_o == $past(word2))
		else $error("word 2 read returned wrong data");
	a_run_no_write: assert property (!prog_mode_reg && !nv_load_i |=>
		$stable(word1) && $stable(word2))
		else $error("configuration changed outside programming mode");
	a_run_no_read:  assert property (!prog_mode_reg |=> !prog_rvalid_o)
		else $error("read answered outside programming mode");
	a_w2_high_ones: assert property (word2[13:5] == 9'h1ff)
		else $error("word 2 upper unimplemented bits not one");
	a_w2_mid_ones:  assert property (word2[3:2] == 2'h3)
		else $error("word 2 bits 3 and 2 not one");
	a_wp_off_all:   assert property (sw_req_i && word2[1:0] == 2'h3 &&
		sw_addr_ext < MEM_END |-> sw_grant_o)
		else $error("write refused with protection off");
	a_wp_small:     assert property (sw_req_i && word2[1:0] == 2'h2 |->
		sw_block_o == (sw_addr_i < 12'h200 || sw_addr_ext >= MEM_END))
		else $error("small protection range wrong");
	a_wp_mid:       assert property (sw_req_i && word2[1:0] == 2'h1 |->
		sw_block_o == (sw_addr_ext < (IS_4K ? 13'h0800 : 13'h0400) ||
		sw_addr_ext >= MEM_END))
		else $error("middle protection range wrong");
	a_wp_all:       assert property (sw_req_i && word2[1:0] == 2'h0 |->
		sw_block_o && !sw_grant_o)
		else $error("write allowed with full protection");
	a_opt_decode:   assert property (opts_o.brownout_mode_opt == word1[9:8] &&
		opts_o.pll_enable_opt == word1[12] && word1[13] && word1[7] && word1[2])
		else $error("word 1 option decode wrong");

	c_prog_write:   cover property (prog_mode_reg && prog_wr_i && hit2 ##1 sw_req_i);
	c_grant:        cover property (sw_grant_o);
	c_block:        cover property (sw_block_o);
	c_read_back:    cover property (prog_mode_reg && prog_rd_i && hit1 ##1 prog_rvalid_o);
endmodule

// file: core/cwwp_word_reg.sv
`timescale 1ns/1ps
module cwwp_word_reg #(
	parameter logic [13:0] IMPL_MASK = 14'h3fff
) (
	input  wire logic        mclk_i,
	input  wire logic        rst_i,
	input  wire logic        load_i,
	input  wire logic [13:0] load_data_i,
	input  wire logic        wr_i,
	input  wire logic [13:0] wr_data_i,
	output logic      [13:0] word_o
);
	logic [13:0] word_reg;

	// Erased state is all ones until the nonvolatile copy arrives
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			word_reg <= cwwp_pkg::WORD_ERASED;
		end else if (wr_i) begin
			word_reg <= wr_data_i;
		end else if (load_i) begin
			word_reg <= load_data_i;
		end
	end

	// Unimplemented positions are forced high on every read
	assign word_o = word_reg | ~IMPL_MASK;
endmodule

// file: test/cwwp_prog_model.sv
`timescale 1ns/1ps
module cwwp_prog_model (
	input  wire logic        mclk_i,
	input  wire logic        rvalid_i,
	output logic             mode_o,
	output logic [13:0]      addr_o,
	output logic             wr_o,
	output logic [13:0]      wdata_o,
	output logic             rd_o
);
	logic rv_seen;
	initial begin
		mode_o = 1'b0;
		addr_o = 14'h0000;
		wr_o = 1'b0;
		wdata_o = 14'h0000;
		rd_o = 1'b0;
		rv_seen = 1'b0;
	end
	task automatic set_mode(input logic on);
		@(posedge mclk_i);
		#1 mode_o = on;
		repeat (3) @(posedge mclk_i);
	endtask
	task automatic write_word(input logic [13:0] a, input logic [13:0] d);
		@(posedge mclk_i);
		#1 addr_o = a;
		wdata_o = (a == cwwp_pkg::CFG2_ADDR) ? (d | 14'h0010) : d;
		wr_o = 1'b1;
		@(posedge mclk_i);
		#1 wr_o = 1'b0;
		// Released lines flip so a stale value is never mistaken for a live one
		addr_o = ~a;
		wdata_o = ~wdata_o;
	endtask
	task automatic read_word(input logic [13:0] a);
		@(posedge mclk_i);
		#1 addr_o = a;
		rd_o = 1'b1;
		@(posedge mclk_i);
		#1 rd_o = 1'b0;
		rv_seen = rvalid_i;
		addr_o = ~a;
	endtask
endmodule

// file: test/tb_top.sv
`timescale 1ns/1ps
module tb_top;
	logic                 mclk = 1'b0;
	logic                 rst = 1'b1;
	logic                 nv_load = 1'b0;
	logic [13:0]          nv_w1 = 14'h0000;
	logic [13:0]          nv_w2 = 14'h0000;
	logic                 sw_req = 1'b0;
	logic [11:0]          sw_addr = 12'h000;
	logic                 mode, wr, rd;
	logic [13:0]          addr, wdata;
	logic [13:0]          rdata [2];
	logic                 rvalid [2], grant [2], block [2];
	cwwp_pkg::cwwp_opts_t opts [2];
	cwwp_pkg::cwwp_wrt_t  sel [2];
	int                   failures = 0, checks_done = 0, cyc = 0;
	always #5 mclk = ~mclk;
	cwwp_prog_model cwwp_prog_model_inst (.mclk_i(mclk), .rvalid_i(rvalid[0]), .mode_o(mode),
		.addr_o(addr), .wr_o(wr), .wdata_o(wdata), .rd_o(rd));
	for (genvar g = 0; g < 2; g++) begin : part
		cwwp_top #(.IS_4K(g == 1)) cwwp_top_inst (.mclk_i(mclk), .rst_i(rst),
			.nv_load_i(nv_load), .nv_word1_i(nv_w1), .nv_word2_i(nv_w2), .prog_mode_i(mode),
			.prog_addr_i(addr), .prog_wr_i(wr), .prog_wdata_i(wdata), .prog_rd_i(rd),
			.prog_rdata_o(rdata[g]), .prog_rvalid_o(rvalid[g]), .sw_req_i(sw_req),
			.sw_addr_i(sw_addr), .sw_grant_o(grant[g]), .sw_block_o(block[g]),
			.opts_o(opts[g]), .self_write_protect_sel_o(sel[g]));
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic final_report();
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [13:0] e, input logic [13:0] s);
		checks_done++;
		if (s !== e) begin
			failures++;
			$display("Error %s expected %h seen %h", nm, e, s);
		end
	endtask
	function automatic logic [13:0] opt_of(input logic [13:0] w);
		return {5'h00, w[cwwp_pkg::PLL_BIT], w[cwwp_pkg::BOR_LSB+:2], w[cwwp_pkg::CP_BIT],
			w[cwwp_pkg::RPIN_BIT], w[cwwp_pkg::PWRT_BIT], w[cwwp_pkg::WDT_BIT],
			w[cwwp_pkg::OSC_LSB+:2]};
	endfunction
	task automatic rd_chk(input logic [13:0] a, input logic [13:0] e);
		cwwp_prog_model_inst.read_word(a);
		chk("rvalid", 14'h0001, {13'h0000, cwwp_prog_model_inst.rv_seen});
		for (int p = 0; p < 2; p++) begin
			chk("rdata", e, rdata[p]);
			chk("rvalid", 14'h0001, {13'h0000, rvalid[p]});
		end
	endtask
	task automatic chk_opts(input logic [13:0] w);
		for (int p = 0; p < 2; p++)
			chk("opts", opt_of(w), {5'h00, opts[p]});
	endtask
	////////////////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		cwwp_prog_model_inst.set_mode(1'b1);
		rd_chk(cwwp_pkg::CFG1_ADDR, 14'h3fff);
		rd_chk(cwwp_pkg::CFG2_ADDR, 14'h3fff);
		chk_opts(14'h3fff);
		$display("test reset done");
	endtask
	task automatic t_word2();
		cwwp_prog_model_inst.write_word(cwwp_pkg::CFG2_ADDR, 14'h0000);
		rd_chk(cwwp_pkg::CFG2_ADDR, 14'h3ffc);
		cwwp_prog_model_inst.write_word(cwwp_pkg::CFG2_ADDR, 14'h0002);
		rd_chk(cwwp_pkg::CFG2_ADDR, 14'h3ffe);
		rd_chk(14'h2009, cwwp_pkg::UNMAPPED_RD);
		// Without mode the port must be dead in both directions
		cwwp_prog_model_inst.set_mode(1'b0);
		cwwp_prog_model_inst.write_word(cwwp_pkg::CFG2_ADDR, 14'h3fff);
		cwwp_prog_model_inst.read_word(cwwp_pkg::CFG2_ADDR);
		chk("rvalid_off", 14'h0000, {13'h0000, cwwp_prog_model_inst.rv_seen});
		// A refused read leaves the last answered word in place
		for (int p = 0; p < 2; p++)
			chk("rdata_off", cwwp_pkg::UNMAPPED_RD, rdata[p]);
		cwwp_prog_model_inst.set_mode(1'b1);
		rd_chk(cwwp_pkg::CFG2_ADDR, 14'h3ffe);
		$display("test word2 done");
	endtask
	task automatic t_protect();
		logic [12:0] pts [8] = '{13'h000, 13'h1ff, 13'h200, 13'h3ff, 13'h400, 13'h7ff,
			13'h800, 13'hfff};
		logic [12:0] first, last;
		logic        blk;
		for (int s = 0; s < 4; s++) begin
			cwwp_prog_model_inst.write_word(cwwp_pkg::CFG2_ADDR, 14'(s));
			for (int p = 0; p < 2; p++)
				chk("sel", 14'(s), {12'h000, sel[p]});
			for (int i = 0; i < 8; i++) begin
				@(posedge mclk);
				#1 sw_req = 1'b1;
				sw_addr = pts[i][11:0];
				#1;
				for (int p = 0; p < 2; p++) begin
					last = p ? 13'h1000 : 13'h0800;
					first = (s == 3) ? 13'h0000 : (s == 2) ? 13'h0200 :
						(s == 1) ? (p ? 13'h0800 : 13'h0400) : 13'h1fff;
					blk = (pts[i] < first) || (pts[i] >= last);
					chk("block", {13'h0000, blk}, {13'h0000, block[p]});
					chk("grant", {13'h0000, !blk}, {13'h0000, grant[p]});
				end
			end
		end
		@(posedge mclk);
		#1 sw_req = 1'b0;
		#1;
		for (int p = 0; p < 2; p++)
			chk("idle", 14'h0000, {12'h000, grant[p], block[p]});
		$display("test protect done");
	endtask
	task automatic t_word1();
		cwwp_prog_model_inst.write_word(cwwp_pkg::CFG1_ADDR, 14'h0000);
		rd_chk(cwwp_pkg::CFG1_ADDR, ~cwwp_pkg::CFG1_IMPL);
		chk_opts(14'h0000);
		@(posedge mclk);
		#1 nv_w1 = 14'h1050;
		nv_w2 = 14'h3ffd;
		nv_load = 1'b1;
		@(posedge mclk);
		#1 nv_load = 1'b0;
		chk_opts(14'h1050);
		rd_chk(cwwp_pkg::CFG1_ADDR, 14'h1050 | ~cwwp_pkg::CFG1_IMPL);
		rd_chk(cwwp_pkg::CFG2_ADDR, 14'h3ffd);
		$display("test word1 done");
	endtask
	task automatic t_reset_mid();
		@(posedge mclk);
		#1 rst = 1'b1;
		repeat (2) @(posedge mclk);
		#1 rst = 0;
		for (int p = 0; p < 2; p++) begin
			chk("rdata_rst", cwwp_pkg::UNMAPPED_RD, rdata[p]);
			chk("rvalid_rst", 14'h0000, {13'h0000, rvalid[p]});
			chk("sel_rst", 14'h0003, {12'h000, sel[p]});
		end
		chk_opts(14'h3fff);
		// The mode synchroniser was cleared, so wait for it to refill
		cwwp_prog_model_inst.set_mode(1'b1);
		rd_chk(cwwp_pkg::CFG1_ADDR, 14'h3fff);
		rd_chk(cwwp_pkg::CFG2_ADDR, 14'h3fff);
		$display("test reset mid done");
	endtask
	////////////////////////////////////////////////////////////////////////////////
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 3000) begin
			failures++;
			final_report();
		end
	end
	initial begin
		repeat (2) @(posedge mclk);
		#1 rst = 1'b0;
		t_reset();
		t_word2();
		t_protect();
		t_word1();
		t_reset_mid();
		final_report();
	end
endmodule
